/* File: ucpt_pkg.sv */
// Shared constants for the ULPI chirp and packet timing block
package ucpt_pkg;
  // Register map (byte addresses) and fields
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_XS_LSB = 0;
  localparam int CTRL_OPM_LSB = 2;
  localparam int CTRL_TERM_BIT = 4;
  localparam int ST_LINE_LSB = 0;
  localparam int ST_RXACT_BIT = 2;
  localparam int ST_TXBUSY_BIT = 3;
  localparam int ST_PRE_BIT = 4;
  localparam int ST_LSRATE_BIT = 5;
  // Transceiver select, operating mode and line state codes
  localparam logic [1:0] XS_HS = 2'h0;
  localparam logic [1:0] XS_FS = 2'h1;
  localparam logic [1:0] XS_LS = 2'h2;
  localparam logic [1:0] XS_PRE = 2'h3;
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [1:0] OPM_CHIRP = 2'h2;
  localparam logic [1:0] LN_SE0 = 2'h0;
  localparam logic [1:0] LN_NSQ = 2'h1;
  localparam logic [1:0] LN_SQ = 2'h2;
  localparam logic [1:0] XS_RESET = XS_FS;
  localparam logic [1:0] OPM_RESET = OPM_NORMAL;
  localparam logic TERM_RESET = 1'b1;
  // Pipeline delays in interface clocks
  localparam int DLY_W = 7;
  localparam logic [6:0] DLY_NONE = 7'h00;
  localparam logic [6:0] RXCMD_JK_DLY = 7'h04;
  localparam logic [6:0] RXCMD_SE0_HS = 7'h04;
  localparam logic [6:0] RXCMD_SE0_FS = 7'h05;
  localparam logic [6:0] RXCMD_SE0_LS = 7'h11;
  localparam logic [6:0] TXS_HS = 7'h02;
  localparam logic [6:0] TXS_FS = 7'h08;
  localparam logic [6:0] TXS_LS = 7'h4B;
  localparam logic [6:0] TXE_PKT_HS = 7'h04;
  localparam logic [6:0] TXE_SOF_HS = 7'h08;
  localparam logic [6:0] RXS_HS = 7'h06;
  localparam logic [6:0] RXE_HS = 7'h06;
  localparam logic [6:0] RXE_FS = 7'h12;
  localparam logic [6:0] RXE_LS = 7'h7B;
  // Full-speed bit time in system clocks, rounded up
  localparam int SYS_CLK_KHZ = 100000;
  localparam int FS_RATE_KBPS = 12000;
  localparam int FS_BIT_CYC = (SYS_CLK_KHZ + FS_RATE_KBPS - 1) / FS_RATE_KBPS;
  localparam int PRE_HDR_BITS = 16;
  localparam int PRE_J_BITS = 1;
  localparam int PRE_GAP_BITS = 4;
  localparam int PRE_CW = 8;
  localparam logic [7:0] PRE_HDR_CYC = 8'(PRE_HDR_BITS * FS_BIT_CYC);
  localparam logic [7:0] PRE_J_CYC = 8'(PRE_J_BITS * FS_BIT_CYC);
  localparam logic [7:0] PRE_REST_CYC = 8'((PRE_GAP_BITS - PRE_J_BITS) * FS_BIT_CYC);
  localparam logic [7:0] PRE_GAP_CYC = 8'(PRE_GAP_BITS * FS_BIT_CYC);
  // Synchroniser bundle layout
  localparam int SB_CLK = 0;
  localparam int SB_LINE = 1;
  localparam int SB_SQ = 3;
  localparam int SB_TXS = 4;
  localparam int SB_STP = 5;
  localparam int SB_SOF = 6;
  localparam int SB_RXS = 7;
  localparam int SB_RXE = 8;
  localparam int SYNC_W = 9;
  typedef enum logic [1:0] {
    PRE_IDLE = 2'h0,
    PRE_HDR = 2'h1,
    PRE_J = 2'h3,
    PRE_GAP = 2'h2
  } ucpt_pre_type;
endpackage

/* File: ucpt_delay.sv */
// Tick-counted pipeline delay with a one-cycle done pulse
`timescale 1ns/10ps
module ucpt_delay (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Control
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic [ucpt_pkg::DLY_W-1:0] count_i,
  // Status
  output logic busy_o,
  output logic done_o,
  output logic [ucpt_pkg::DLY_W-1:0] elapsed_o
);
  import ucpt_pkg::*;
  logic [DLY_W-1:0] cnt_q;

  // A restart while busy drops the old event; the newest one wins
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_q <= DLY_NONE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      elapsed_o <= DLY_NONE;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        elapsed_o <= DLY_NONE;
        cnt_q <= count_i;
        busy_o <= (count_i != DLY_NONE);
        done_o <= (count_i == DLY_NONE);
      end else if (busy_o && tick_i) begin
        elapsed_o <= elapsed_o + 1'b1;
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == 7'h01) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: ucpt_top.sv */
// Transceiver-side chirp, pipeline delay and preamble timing
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
// Functional notes
// RQ1 - Sleeping peripheral link restarts its clock within 5.6 ms; chirp K done by 7 ms.
// RQ2 - Host link with no peripheral chirp keeps SE0 until bus reset ends.
// RQ3 - Host answers 2.5 us peripheral K with alternating chirp within 100 us.
// RQ4 - Each host chirp K or J lasts 40 to 60 us.
// RQ5 - Peripheral needs K-J-K-J-K-J, each at least 2.5 us, to see host chirp.
// RQ6 - Peripheral then sets termination select 0 and normal mode, entering high speed.
// RQ7 - High speed reports not-squelch as 01 and squelch as 10 on line state.
// RQ8 - Host returns to normal mode after chirp before sending packets.
// RQ9 - Line state report lags J/K by 4 clocks; SE0 by 4, 4-6, 16-18.
// RQ10 - Transmit start, receive start and receive end delays follow the speed table.
// RQ11 - High-speed transmit end delay is 3-4 clocks, 6-9 for start-of-frame.
// RQ12 - Host waits 15-24, 7-18 or 77-247 clocks between its transmit packets.
// RQ13 - That wait counts from stop at high speed, SE0-to-J report at full.
// RQ14 - Link waits 1-14, 7-18 or 77-247 clocks before answering a receive.
// RQ15 - That wait counts from receive end, or SE0-to-J report at lower speeds.
// RQ16 - Peripheral link accepts receive packets one clock apart.
// RQ17 - Response time-out is 92, 80 or 718 clocks after transmitting.
// RQ18 - Select code 11 enters preamble mode, otherwise behaving as full speed.
// RQ19 - In preamble mode each packet gets a full-speed header, then goes low speed.
// RQ20 - At least four full-speed bit times between header PID and low-speed sync.
// RQ21 - Drive J for at least one full-speed bit time after the header PID.
// RQ22 - Preamble mode also receives low-speed packets from the full-speed bus.
// RQ23 - Peripheral starts chirp after 2.5 us of SE0, in high speed chirp mode.
// RQ24 - Operating mode 10 selects chirp transmit and receive.
// RQ25 - Link measures its windows with interface-clock counters restarted per event.
module ucpt_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [ucpt_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Interface clock and bus-side events
  input wire logic ulpi_clk_i,
  input wire logic [1:0] line_i,
  input wire logic squelch_i,
  input wire logic rx_sync_i,
  input wire logic rx_end_i,
  // Link-side transmit events
  input wire logic tx_start_i,
  input wire logic tx_stp_i,
  input wire logic tx_sof_i,
  // Event and mode outputs
  output logic [1:0] linestate_o,
  output logic rxcmd_valid_o,
  output logic [1:0] rxcmd_line_o,
  output logic tx_go_o,
  output logic tx_end_o,
  output logic rx_active_o,
  output logic pre_hdr_o,
  output logic pre_drive_j_o,
  output logic ls_rate_o,
  output logic term_sel_o
);
  import ucpt_pkg::*;

  logic [SYNC_W-1:0] s1_q, s2_q, s3_q, stab_q, prev_q;
  logic [1:0] xs_q, opm_q;
  logic [1:0] line_d;
  logic tick, txs_ev, stp_ev, rxs_ev, rxe_ev, line_chg, pre_done, sof_q;
  logic [DLY_W-1:0] rxc_cnt, txs_cnt, txe_cnt, rxs_cnt, rxe_cnt;
  logic [DLY_W-1:0] rxc_el, txs_el, txe_el, rxe_el;
  logic txs_busy, rxs_done, rxe_done, txs_start;
  ucpt_pre_type pre_q;
  logic [PRE_CW-1:0] pre_cnt_q, gap_cyc_q;

  // Pin inputs: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      stab_q <= '0;
      prev_q <= '0;
    end else begin
      s1_q <= {rx_end_i, rx_sync_i, tx_sof_i, tx_stp_i, tx_start_i, squelch_i, line_i, ulpi_clk_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        stab_q <= s3_q;
      end
      prev_q <= stab_q;
    end
  end

  // All pipeline delays count rising edges of the interface clock; the preamble counts system clocks
  assign tick = stab_q[SB_CLK] & ~prev_q[SB_CLK];
  assign txs_ev = stab_q[SB_TXS] & ~prev_q[SB_TXS];
  assign stp_ev = stab_q[SB_STP] & ~prev_q[SB_STP];
  assign rxs_ev = stab_q[SB_RXS] & ~prev_q[SB_RXS];
  assign rxe_ev = stab_q[SB_RXE] & ~prev_q[SB_RXE];

  // Avalon slave: one wait cycle, then the access completes
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      xs_q <= XS_RESET;
      opm_q <= OPM_RESET;
      term_sel_o <= TERM_RESET;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        avs_readdata_o <= 32'h0000_0000;
        unique case (avs_address_i)
          REG_CTRL: begin
            avs_readdata_o[CTRL_XS_LSB +: 2] <= xs_q;
            avs_readdata_o[CTRL_OPM_LSB +: 2] <= opm_q;
            avs_readdata_o[CTRL_TERM_BIT] <= term_sel_o;
          end
          REG_STATUS: begin
            avs_readdata_o[ST_LINE_LSB +: 2] <= linestate_o;
            avs_readdata_o[ST_RXACT_BIT] <= rx_active_o;
            avs_readdata_o[ST_TXBUSY_BIT] <= txs_busy;
            avs_readdata_o[ST_PRE_BIT] <= (pre_q != PRE_IDLE);
            avs_readdata_o[ST_LSRATE_BIT] <= ls_rate_o;
          end
          default: begin
          end
        endcase
      end
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL) begin
        xs_q <= avs_writedata_i[CTRL_XS_LSB +: 2]; // [RQ18]
        opm_q <= avs_writedata_i[CTRL_OPM_LSB +: 2];
        term_sel_o <= avs_writedata_i[CTRL_TERM_BIT];
      end
    end
  end

  // Line state seen by the link; chirp mode passes the raw line
  always_comb begin
    line_d = stab_q[SB_LINE +: 2]; // [RQ24]
    if (xs_q == XS_HS && opm_q == OPM_NORMAL) begin
      line_d = stab_q[SB_SQ] ? LN_SQ : LN_NSQ; // [RQ7]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      linestate_o <= LN_SE0;
      rxcmd_line_o <= LN_SE0;
    end else begin
      linestate_o <= line_d;
      if (line_chg) begin
        rxcmd_line_o <= line_d;
      end
    end
  end
  assign line_chg = (line_d != linestate_o);

  // Delay selection per speed; preamble sends and receives at low-speed pace
  always_comb begin
    rxc_cnt = RXCMD_JK_DLY; // [RQ9]
    txs_cnt = TXS_FS;
    txe_cnt = DLY_NONE;
    rxs_cnt = DLY_NONE;
    rxe_cnt = RXE_FS;
    unique case (xs_q)
      XS_HS: begin
        txs_cnt = TXS_HS; // [RQ10]
        txe_cnt = stab_q[SB_SOF] ? TXE_SOF_HS : TXE_PKT_HS; // [RQ11]
        rxs_cnt = RXS_HS;
        rxe_cnt = RXE_HS;
        if (line_d == LN_SE0) begin
          rxc_cnt = RXCMD_SE0_HS;
        end
      end
      XS_LS: begin
        txs_cnt = TXS_LS;
        rxe_cnt = RXE_LS;
        if (line_d == LN_SE0) begin
          rxc_cnt = RXCMD_SE0_LS;
        end
      end
      default: begin
        if (xs_q == XS_PRE) begin
          txs_cnt = TXS_LS; // [RQ19]
          rxe_cnt = RXE_LS; // [RQ22]
        end
        if (line_d == LN_SE0) begin
          rxc_cnt = RXCMD_SE0_FS; // [RQ18]
        end
      end
    endcase
  end

  assign txs_start = (txs_ev && xs_q != XS_PRE) || pre_done;

  ucpt_delay u_rxc (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tick_i(tick), .start_i(line_chg),
    .count_i(rxc_cnt), .busy_o(), .done_o(rxcmd_valid_o), .elapsed_o(rxc_el));
  ucpt_delay u_txs (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tick_i(tick), .start_i(txs_start),
    .count_i(txs_cnt), .busy_o(txs_busy), .done_o(tx_go_o), .elapsed_o(txs_el));
  ucpt_delay u_txe (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tick_i(tick), .start_i(stp_ev),
    .count_i(txe_cnt), .busy_o(), .done_o(tx_end_o), .elapsed_o(txe_el));
  ucpt_delay u_rxs (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tick_i(tick), .start_i(rxs_ev),
    .count_i(rxs_cnt), .busy_o(), .done_o(rxs_done), .elapsed_o());
  ucpt_delay u_rxe (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tick_i(tick), .start_i(rxe_ev),
    .count_i(rxe_cnt), .busy_o(), .done_o(rxe_done), .elapsed_o(rxe_el));

  // Receive framing; a start in the same cycle as an end wins for back-to-back packets
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_active_o <= 1'b0;
      sof_q <= 1'b0;
    end else begin
      if (rxs_done) begin
        rx_active_o <= 1'b1;
      end else if (rxe_done) begin
        rx_active_o <= 1'b0;
      end
      if (stp_ev) begin
        sof_q <= stab_q[SB_SOF];
      end
    end
  end

  // Preamble header, held J, remaining gap, then the low-speed packet
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pre_q <= PRE_IDLE;
      pre_cnt_q <= '0;
      pre_hdr_o <= 1'b0;
      pre_drive_j_o <= 1'b0;
      ls_rate_o <= 1'b0;
    end else begin
      if (pre_q != PRE_IDLE && pre_cnt_q != '0) begin
        pre_cnt_q <= pre_cnt_q - 1'b1;
      end
      unique case (pre_q)
        PRE_IDLE: begin
          if (txs_ev && xs_q == XS_PRE) begin
            pre_q <= PRE_HDR; // [RQ19]
            pre_cnt_q <= PRE_HDR_CYC - 1'b1;
            pre_hdr_o <= 1'b1;
          end
        end
        PRE_HDR: begin
          if (pre_cnt_q == '0) begin
            pre_q <= PRE_J;
            pre_cnt_q <= PRE_J_CYC - 1'b1;
            pre_hdr_o <= 1'b0;
            pre_drive_j_o <= 1'b1; // [RQ21]
          end
        end
        PRE_J: begin
          if (pre_cnt_q == '0) begin
            pre_q <= PRE_GAP;
            pre_cnt_q <= PRE_REST_CYC - 1'b1; // [RQ20]
            pre_drive_j_o <= 1'b0;
          end
        end
        PRE_GAP: begin
          if (pre_cnt_q == '0) begin
            pre_q <= PRE_IDLE;
            ls_rate_o <= 1'b1;
          end
        end
      endcase
      // The set at the end of the gap wins over a coinciding transmit end
      if (tx_end_o && !pre_done) begin
        ls_rate_o <= 1'b0;
      end
    end
  end
  assign pre_done = (pre_q == PRE_GAP) && (pre_cnt_q == '0);

  // Cycles since the header ended, read only by the checks below
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || pre_hdr_o) begin
      gap_cyc_q <= '0;
    end else if (gap_cyc_q != '1) begin
      gap_cyc_q <= gap_cyc_q + 1'b1;
    end
  end

  sequence s_hdr_end;
    $fell(pre_hdr_o);
  endsequence
  sequence s_j_then_quiet;
    pre_drive_j_o [*8] ##1 pre_drive_j_o ##1 !pre_drive_j_o;
  endsequence

  a_squelch_report: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ7]
    (xs_q == XS_HS && opm_q == OPM_NORMAL && stab_q[SB_SQ]) |=> linestate_o == LN_SQ)
    else $error("squelch not reported as 10");
  a_nsq_report: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ7]
    (xs_q == XS_HS && opm_q == OPM_NORMAL && !stab_q[SB_SQ]) |=> linestate_o == LN_NSQ)
    else $error("not-squelch not reported as 01");
  a_rxcmd_jk_delay: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ9]
    (rxcmd_valid_o && rxcmd_line_o != LN_SE0) |-> rxc_el == RXCMD_JK_DLY)
    else $error("line report delay not 4 clocks");
  a_rxcmd_ls_se0: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ9]
    (rxcmd_valid_o && xs_q == XS_LS && rxcmd_line_o == LN_SE0) |-> rxc_el inside {[16:18]})
    else $error("low-speed SE0 report delay out of range");
  a_txs_ls_delay: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ10]
    (tx_go_o && xs_q == XS_LS) |-> txs_el inside {[74:75]})
    else $error("low-speed transmit start delay out of range");
  a_rxe_hs_delay: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ10]
    (rxe_done && xs_q == XS_HS) |-> rxe_el inside {[5:6]})
    else $error("high-speed receive end delay out of range");
  a_txe_sof_delay: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ11]
    (tx_end_o && xs_q == XS_HS) |-> (sof_q ? txe_el inside {[6:9]} : txe_el inside {[3:4]}))
    else $error("high-speed transmit end delay out of range");
  a_pre_hdr_first: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ19]
    (txs_ev && xs_q == XS_PRE && pre_q == PRE_IDLE) |=> pre_hdr_o && !tx_go_o)
    else $error("preamble header not started on transmit");
  a_pre_j_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ21]
    s_hdr_end |-> s_j_then_quiet)
    else $error("J not held one full-speed bit after header");
  a_pre_gap_len: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ20]
    $rose(ls_rate_o) |-> gap_cyc_q >= PRE_GAP_CYC)
    else $error("gap before low-speed sync too short");
  a_pre_rx_ls: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ22]
    (rxe_done && xs_q == XS_PRE) |-> rxe_el inside {[122:123]})
    else $error("preamble receive not at low-speed pace");
endmodule

/* File: ucpt_link_model.sv */
// Link-side stand-in: interface clock and bus and link event drivers
`timescale 1ns/10ps
module ucpt_link_model (
  // System clock
  input wire logic clk_sys_i,
  // Interface clock and bus-side events
  output logic ulpi_clk_o,
  output logic [1:0] line_o,
  output logic squelch_o,
  output logic rx_sync_o,
  output logic rx_end_o,
  // Link-side transmit events
  output logic tx_start_o,
  output logic tx_stp_o,
  output logic tx_sof_o
);
  logic [3:0] ev_q;
  assign {tx_stp_o, tx_start_o, rx_end_o, rx_sync_o} = ev_q;
  // Free-running, phase unrelated to the system clock
  initial begin
    ulpi_clk_o = 1'b0;
    #3.1;
    forever #62.5 ulpi_clk_o = ~ulpi_clk_o;
  end
  initial begin
    line_o = 2'h1;
    squelch_o = 1'b0;
    ev_q = 4'h0;
    tx_sof_o = 1'b0;
  end
  // Only a rising edge counts, so the line drops for three cycles first
  task automatic fire(input int k, input logic sof);
    @(posedge clk_sys_i);
    ev_q[k] <= 1'b0;
    tx_sof_o <= sof;
    // Low for three cycles; the pin filter swallows a dip of one cycle
    repeat (3) @(posedge clk_sys_i);
    ev_q[k] <= 1'b1;
  endtask
  task automatic set_line(input logic [1:0] v, input logic sq);
    @(posedge clk_sys_i);
    line_o <= v;
    squelch_o <= sq;
  endtask
  // Decision windows are counted in interface clocks
  task automatic wait_ticks(input int n);
    repeat (n) @(posedge ulpi_clk_o);
    @(posedge clk_sys_i);
  endtask
endmodule

/* File: ucpt_top_tb.sv */
// Self-checking bench for the chirp, pipeline delay and preamble timing block
`timescale 1ns/10ps
module ucpt_top_tb;
  import ucpt_pkg::*;
  logic clk_sys_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic ulpi_clk_i, squelch_i, rx_sync_i, rx_end_i, tx_start_i, tx_stp_i, tx_sof_i;
  logic [1:0] line_i, linestate_o, rxcmd_line_o;
  logic rxcmd_valid_o, tx_go_o, tx_end_o, rx_active_o, pre_hdr_o, pre_drive_j_o, ls_rate_o, term_sel_o;
  int n_errors = 0;
  int checks = 0;
  int se0_lo[3] = '{4, 4, 16};
  int se0_hi[3] = '{4, 6, 18};
  int txs_lo[3] = '{1, 6, 74};
  int txs_hi[3] = '{2, 10, 75};
  int rxe_lo[3] = '{5, 17, 122};
  int rxe_hi[3] = '{6, 18, 123};

  ucpt_top dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .ulpi_clk_i(ulpi_clk_i),
    .line_i(line_i), .squelch_i(squelch_i), .rx_sync_i(rx_sync_i), .rx_end_i(rx_end_i),
    .tx_start_i(tx_start_i), .tx_stp_i(tx_stp_i), .tx_sof_i(tx_sof_i), .linestate_o(linestate_o),
    .rxcmd_valid_o(rxcmd_valid_o), .rxcmd_line_o(rxcmd_line_o), .tx_go_o(tx_go_o), .tx_end_o(tx_end_o),
    .rx_active_o(rx_active_o), .pre_hdr_o(pre_hdr_o), .pre_drive_j_o(pre_drive_j_o),
    .ls_rate_o(ls_rate_o), .term_sel_o(term_sel_o));
  ucpt_link_model lm (.clk_sys_i(clk_sys_i), .ulpi_clk_o(ulpi_clk_i), .line_o(line_i),
    .squelch_o(squelch_i), .rx_sync_o(rx_sync_i), .rx_end_o(rx_end_i), .tx_start_o(tx_start_i),
    .tx_stp_o(tx_stp_i), .tx_sof_o(tx_sof_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic finish_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [31:0] ctrl(input logic [1:0] xs, input logic [1:0] opm, input logic term);
    ctrl = (32'(term) << CTRL_TERM_BIT) | (32'(opm) << CTRL_OPM_LSB) | (32'(xs) << CTRL_XS_LSB);
  endfunction

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = rxcmd_valid_o;
      1: pick = tx_go_o;
      2: pick = tx_end_o;
      3: pick = rx_active_o;
      4: pick = (linestate_o === LN_SQ);
      5: pick = (linestate_o === LN_NSQ);
      6: pick = pre_hdr_o;
      7: pick = pre_drive_j_o;
      default: pick = ls_rate_o;
    endcase
  endfunction

  // One access: held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int t;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    t = 0;
    do begin
      @(posedge clk_sys_i);
      t++;
    end while (avs_waitrequest_o !== 1'b0 && t < 100);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    chk(t < 100, "bus answer");
  endtask

  // Cycles and interface clock edges while the picked output stays at lvl
  task automatic span(input int sel, input logic lvl, output int c, output int n);
    logic u;
    c = 0;
    n = 0;
    // Let the edge that launched the last pulse settle first
    #1;
    u = ulpi_clk_i;
    while (pick(sel) === lvl && c < 20000) begin
      @(posedge clk_sys_i);
      #1;
      c++;
      if (ulpi_clk_i && !u) n++;
      u = ulpi_clk_i;
    end
  endtask

  // Synchroniser phase may add one edge to the count
  task automatic dly(input int sel, input logic lvl, input int lo, input int hi, input string m);
    int c, n;
    span(sel, lvl, c, n);
    chk(c < 20000 && n >= lo && n <= hi + 1, m);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, REG_CTRL, 32'h0000_0000, q);
    chk(q === ctrl(XS_RESET, OPM_RESET, TERM_RESET) && term_sel_o === 1'b1, "ctrl after reset");
    bus(1'b1, REG_STATUS, 32'hFFFF_FFFF, q);
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk(q === 32'h0000_0001, "status read-only");
    bus(1'b1, 4'h8, 32'hFFFF_FFFF, q);
    bus(1'b0, 4'h8, 32'h0000_0000, q);
    chk(q === 32'h0000_0000, "unmapped read");
    bus(1'b1, REG_CTRL, ctrl(XS_LS, OPM_CHIRP, 1'b0), q);
    bus(1'b0, REG_CTRL, 32'h0000_0000, q);
    chk(q === ctrl(XS_LS, OPM_CHIRP, 1'b0) && term_sel_o === 1'b0, "chirp mode write");
    $display("t_regs done");
  endtask

  task automatic t_line();
    logic [31:0] q;
    for (int i = 0; i < 3; i++) begin
      // High speed passes the raw line in every mode except normal
      bus(1'b1, REG_CTRL, ctrl(2'(i), (i == 0) ? OPM_CHIRP : OPM_NORMAL, 1'b1), q);
      lm.set_line(2'h2, 1'b0);
      dly(0, 1'b0, 4, 4, "K report delay");
      chk(rxcmd_line_o === 2'h2, "K report value");
      lm.set_line(LN_SE0, 1'b0);
      dly(0, 1'b0, se0_lo[i], se0_hi[i], "SE0 report delay");
      chk(rxcmd_line_o === LN_SE0, "SE0 report value");
      lm.set_line(2'h1, 1'b0);
      dly(0, 1'b0, 4, 4, "J report delay");
    end
    $display("t_line done");
  endtask

  task automatic t_tx();
    logic [31:0] q;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, REG_CTRL, ctrl(2'(i), OPM_NORMAL, 1'b1), q);
      lm.fire(2, 1'b0);
      dly(1, 1'b0, txs_lo[i], txs_hi[i], "tx start delay");
      lm.wait_ticks(20);
    end
    bus(1'b1, REG_CTRL, ctrl(XS_HS, OPM_NORMAL, 1'b0), q);
    lm.fire(3, 1'b0);
    dly(2, 1'b0, 3, 4, "tx end packet");
    lm.wait_ticks(20);
    lm.fire(3, 1'b1);
    dly(2, 1'b0, 6, 9, "tx end frame start");
    $display("t_tx done");
  endtask

  task automatic t_rx();
    logic [31:0] q;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, REG_CTRL, ctrl(2'(i), OPM_NORMAL, 1'b1), q);
      lm.fire(0, 1'b0);
      dly(3, 1'b0, (i == 0) ? 5 : 0, (i == 0) ? 6 : 0, "rx start delay");
      lm.fire(1, 1'b0);
      dly(3, 1'b1, rxe_lo[i], rxe_hi[i], "rx end delay");
      lm.wait_ticks(1);
    end
    $display("t_rx done");
  endtask

  // Bus reset SE0, then host chirp K-J-K-J-K-J of 40 us states
  task automatic t_chirp();
    logic [31:0] q;
    bus(1'b1, REG_CTRL, ctrl(XS_HS, OPM_CHIRP, 1'b1), q);
    lm.set_line(LN_SE0, 1'b0);
    repeat (300) @(posedge clk_sys_i);
    chk(linestate_o === LN_SE0, "reset SE0 passed raw");
    for (int k = 0; k < 6; k++) begin
      lm.set_line(2'(2 - k % 2), 1'b0);
      repeat (4000) @(posedge clk_sys_i);
      chk(linestate_o === 2'(2 - k % 2), "chirp state passed raw");
    end
    $display("t_chirp done");
  endtask

  task automatic t_sq();
    logic [31:0] q;
    int c, n;
    bus(1'b1, REG_CTRL, ctrl(XS_HS, OPM_NORMAL, 1'b0), q);
    lm.set_line(2'h1, 1'b1);
    span(4, 1'b0, c, n);
    chk(c < 200, "squelch reported as 10");
    lm.set_line(2'h1, 1'b0);
    span(5, 1'b0, c, n);
    chk(c < 200, "not-squelch reported as 01");
    $display("t_sq done");
  endtask

  task automatic t_pre();
    logic [31:0] q;
    int c, g, n;
    bus(1'b1, REG_CTRL, ctrl(XS_PRE, OPM_NORMAL, 1'b1), q);
    lm.fire(2, 1'b0);
    span(6, 1'b0, c, n);
    chk(c < 10, "header starts");
    span(6, 1'b1, c, n);
    chk(c == PRE_HDR_BITS * FS_BIT_CYC && pre_drive_j_o === 1'b1, "header length, J follows");
    span(7, 1'b1, c, n);
    chk(c >= 9, "J held one bit time");
    span(8, 1'b0, g, n);
    chk(c + g >= PRE_GAP_BITS * FS_BIT_CYC && ls_rate_o === 1'b1, "four bit gap before slow packet");
    dly(1, 1'b0, 74, 75, "slow packet start delay");
    lm.fire(3, 1'b0);
    span(8, 1'b1, c, n);
    chk(c < 30, "slow rate ends with packet");
    lm.set_line(LN_SE0, 1'b0);
    dly(0, 1'b0, 4, 6, "SE0 report as full speed");
    lm.set_line(2'h1, 1'b0);
    dly(0, 1'b0, 4, 4, "J report");
    lm.fire(0, 1'b0);
    dly(3, 1'b0, 0, 0, "slow rx start");
    lm.fire(1, 1'b0);
    dly(3, 1'b1, 122, 123, "slow rx end");
    $display("t_pre done");
  endtask

  initial begin
    reset_i = 1'b1;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_regs();
    t_line();
    t_tx();
    t_rx();
    t_chirp();
    t_sq();
    t_pre();
    finish_test();
  end

  // Whole run is well under this span
  initial begin
    #1000000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
